// ---- hdl/mvs_defs.svh ----
// constants for the modbus rtu visibility slave
`ifndef MVS_DEFS_SVH
`define MVS_DEFS_SVH
`define MVS_CLK_HZ 40000000
`define MVS_BAUD 9600
`define MVS_BIT_CYC (`MVS_CLK_HZ / `MVS_BAUD)
`define MVS_HALF_CYC (`MVS_BIT_CYC / 2)
`define MVS_GAP_CHARS 4
`define MVS_GAP_CYC (`MVS_BIT_CYC * 11 * `MVS_GAP_CHARS)
`define MVS_SLAVE_ADDR 8'h01
`define MVS_FUNC_READ 8'h03
`define MVS_EXC_FLAG 8'h80
`define MVS_EXC_FUNC 8'h01
`define MVS_EXC_ADDR 8'h02
`define MVS_EXC_QTY 8'h03
`define MVS_EXC_BUSY 8'h06
`define MVS_VIS_REG_ADDR 16'h0000
`define MVS_CRC_INIT 16'hFFFF
`define MVS_CRC_POLY 16'hA001
`define MVS_REQ_LEN 8
`define MVS_MAX_FRAME 8'hFF
`endif

// ---- hdl/mvs_pkg.sv ----
// types for the modbus rtu visibility slave
package mvs_pkg;
  typedef enum logic [1:0] {MVS_TX_IDLE, MVS_TX_START, MVS_TX_BITS, MVS_TX_STOP} mvs_tx_state_t;
  typedef enum logic [1:0] {MVS_RX_IDLE, MVS_RX_START, MVS_RX_BITS} mvs_rx_state_t;
endpackage

// ---- hdl/mvs_crc_if.sv ----
// crc engine connection between the slave and its crc unit
`timescale 1ns/1ps
interface mvs_crc_if;
  logic clear;
  logic load;
  logic [7:0] data;
  logic busy;
  logic [15:0] crc;
  modport master (output clear, output load, output data, input busy, input crc);
  modport engine (input clear, input load, input data, output busy, output crc);
endinterface

// ---- hdl/mvs_crc.sv ----
// bit-serial crc-16 engine, eight shift steps per byte
`timescale 1ns/1ps
`include "mvs_defs.svh"
module mvs_crc (
  input wire logic clk_sys,
  input wire logic reset,
  mvs_crc_if.engine port
);
  logic [15:0] acc_reg, acc_next;
  logic [3:0] cnt_reg, cnt_next;
  // next accumulator: load xors byte, then eight shifts
  always_comb begin
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    if (port.clear) begin
      acc_next = `MVS_CRC_INIT;
      cnt_next = 4'h0;
    end else if (port.load && cnt_reg == 4'h0) begin
      acc_next = acc_reg ^ {8'h00, port.data};
      cnt_next = 4'h8;
    end else if (cnt_reg != 4'h0) begin
      acc_next = {1'b0, acc_reg[15:1]} ^ (acc_reg[0] ? `MVS_CRC_POLY : 16'h0000);
      cnt_next = cnt_reg - 4'h1;
    end
  end
  // register the engine state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_reg <= `MVS_CRC_INIT;
      cnt_reg <= 4'h0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
    end
  end
  assign port.busy = (cnt_reg != 4'h0);
  assign port.crc = acc_reg;
  // a loaded byte keeps the engine busy for exactly eight shift steps
  property p_eight_steps; @(posedge clk_sys) disable iff (reset)
    (port.load && !port.clear && cnt_reg == 4'h0) |=> port.busy [*8] ##1 !port.busy; endproperty
  a_eight_steps: assert property (p_eight_steps) else $error("crc step count wrong");
  property p_init; @(posedge clk_sys) disable iff (reset) port.clear |=> acc_reg == 16'hFFFF; endproperty
  a_init: assert property (p_init) else $error("crc not initialised");
endmodule

// ---- hdl/mvs_slave.sv ----
// modbus rtu slave: uart 8e1, request check, read-holding reply
`timescale 1ns/1ps
`include "mvs_defs.svh"
// Contract
// - characters are start, eight data, even parity, one stop, at 9600 baud
// - frame characters go back to back; an idle gap ends the frame
// - crc covers every frame byte from address through data
// - crc appended low byte first, high byte last
// - received crc recomputed and compared; mismatch drops the frame
// - multi-byte fields travel most significant byte first
// - only function 03 is supported; others are rejected
// - one read-only 16-bit visibility register at register address 0
// - answers slave address 01 only, ignores others
// - reply is address, function, byte count, data high first, crc
// - crc accumulator starts at all ones
// - each byte xored into the low accumulator byte first
// - shift right, zero in, xor polynomial when lsb out was one
// - eight shifts per byte, final content is the crc
module mvs_slave #(
  parameter int GAP_CYC = `MVS_GAP_CYC,
  parameter int BIT_CYC = `MVS_BIT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic rx_line,
  output logic tx_line_reg,
  output logic tx_en_reg,
  input wire logic [15:0] visibility_range_meters,
  output logic frame_err_reg
);
  mvs_crc_if crc_bus ();
  mvs_crc u_crc (.clk_sys(clk_sys), .reset(reset), .port(crc_bus));

  function automatic logic par_even(input logic [7:0] b);
    return ^b;
  endfunction

  // receiver state
  mvs_pkg::mvs_rx_state_t rx_st_reg, rx_st_next;
  logic [12:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [8:0] rx_sh_reg, rx_sh_next;
  logic [7:0] rx_len_reg, rx_len_next;
  logic rx_bad_reg, rx_bad_next;
  logic [31:0] gap_reg, gap_next;
  logic [7:0] rq_reg [0:7];
  logic [7:0] rq_next [0:7];
  logic byte_ok, frame_end;

  // receive characters and collect the request bytes
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_len_next = rx_len_reg;
    rx_bad_next = rx_bad_reg;
    rq_next = rq_reg;
    byte_ok = 1'b0;
    frame_end = 1'b0;
    gap_next = (rx_st_reg == mvs_pkg::MVS_RX_IDLE && gap_reg < 32'(GAP_CYC)) ? gap_reg + 32'd1 : gap_reg;
    unique case (rx_st_reg)
      mvs_pkg::MVS_RX_IDLE: begin
        if (!rx_line) begin
          rx_st_next = mvs_pkg::MVS_RX_START;
          rx_cnt_next = 13'(BIT_CYC / 2);
          gap_next = 32'd0;
        end else if (gap_reg == 32'(GAP_CYC - 1)) begin
          frame_end = (rx_len_reg != 8'h00) || rx_bad_reg;
        end
      end
      mvs_pkg::MVS_RX_START: begin
        if (rx_cnt_reg != 13'h0) begin
          rx_cnt_next = rx_cnt_reg - 13'h1;
        end else if (rx_line) begin
          rx_st_next = mvs_pkg::MVS_RX_IDLE; // glitch, not a start bit
        end else begin
          rx_st_next = mvs_pkg::MVS_RX_BITS;
          rx_cnt_next = 13'(BIT_CYC - 1);
          rx_bit_next = 4'h0;
        end
      end
      mvs_pkg::MVS_RX_BITS: begin
        if (rx_cnt_reg != 13'h0) begin
          rx_cnt_next = rx_cnt_reg - 13'h1;
        end else begin
          rx_cnt_next = 13'(BIT_CYC - 1);
          rx_bit_next = rx_bit_reg + 4'h1;
          if (rx_bit_reg < 4'h9) begin
            rx_sh_next = {rx_line, rx_sh_reg[8:1]}; // lsb first, parity last
          end else begin
            rx_st_next = mvs_pkg::MVS_RX_IDLE;
            if (!rx_line || par_even(rx_sh_reg[7:0]) != rx_sh_reg[8]) begin
              rx_bad_next = 1'b1;
            end else begin
              byte_ok = 1'b1;
              if (rx_len_reg < 8'(`MVS_REQ_LEN)) begin
                rq_next[rx_len_reg[2:0]] = rx_sh_reg[7:0];
              end
              if (rx_len_reg != `MVS_MAX_FRAME) begin
                rx_len_next = rx_len_reg + 8'h01;
              end
            end
          end
        end
      end
      default: rx_st_next = mvs_pkg::MVS_RX_IDLE;
    endcase
    if (frame_end) begin
      rx_len_next = 8'h00;
      rx_bad_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_st_reg <= mvs_pkg::MVS_RX_IDLE;
      rx_cnt_reg <= 13'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_len_reg <= 8'h00;
      rx_bad_reg <= 1'b0;
      gap_reg <= 32'd0;
      for (int i = 0; i < 8; i++) rq_reg[i] <= 8'h00;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_len_reg <= rx_len_next;
      rx_bad_reg <= rx_bad_next;
      gap_reg <= gap_next;
      rq_reg <= rq_next;
    end
  end

  // reply builder and transmitter
  mvs_pkg::mvs_tx_state_t tx_st_reg, tx_st_next;
  logic [7:0] rp_reg [0:6];
  logic [7:0] rp_next [0:6];
  logic [2:0] rp_len_reg, rp_len_next, rp_idx_reg, rp_idx_next;
  logic [12:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_sh_reg, tx_sh_next;
  logic tx_line_next, tx_en_next, frame_err_next;
  logic crc_run_reg, crc_run_next, crc_pend_reg, crc_pend_next;
  logic [2:0] crc_idx_reg, crc_idx_next;
  logic [15:0] start_addr, qty, rx_crc;
  logic [7:0] exc;

  assign start_addr = {rq_reg[2], rq_reg[3]};
  assign qty = {rq_reg[4], rq_reg[5]};
  assign rx_crc = {rq_reg[7], rq_reg[6]};

  // select the exception that applies to the held request
  always_comb begin
    exc = 8'h00;
    if (rq_reg[1] != `MVS_FUNC_READ) exc = `MVS_EXC_FUNC;
    else if (qty != 16'h0001) exc = `MVS_EXC_QTY;
    else if (start_addr != `MVS_VIS_REG_ADDR) exc = `MVS_EXC_ADDR;
  end

  // crc over received bytes, then verdict and reply crc
  always_comb begin
    crc_bus.clear = 1'b0;
    crc_bus.load = 1'b0;
    crc_bus.data = 8'h00;
    crc_run_next = crc_run_reg;
    crc_pend_next = crc_pend_reg;
    crc_idx_next = crc_idx_reg;
    rp_next = rp_reg;
    rp_len_next = rp_len_reg;
    rp_idx_next = rp_idx_reg;
    frame_err_next = frame_err_reg;
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    tx_line_next = tx_line_reg;
    tx_en_next = tx_en_reg;
    if (byte_ok && rx_len_reg == 8'h00) begin
      frame_err_next = 1'b0;
    end
    if (frame_end && tx_st_reg == mvs_pkg::MVS_TX_IDLE && !rx_bad_reg
        && rx_len_reg == 8'(`MVS_REQ_LEN) && rq_reg[0] == `MVS_SLAVE_ADDR) begin
      crc_bus.clear = 1'b1;
      crc_run_next = 1'b1;
      crc_pend_next = 1'b0;
      crc_idx_next = 3'h0;
    end else if (frame_end && rx_bad_reg) begin
      frame_err_next = 1'b1;
    end else if (crc_run_reg && !crc_bus.busy && !crc_pend_reg) begin
      if (crc_idx_reg != 3'h6) begin
        crc_bus.load = 1'b1;
        crc_bus.data = rq_reg[crc_idx_reg];
        crc_idx_next = crc_idx_reg + 3'h1;
      end else if (crc_bus.crc != rx_crc) begin
        crc_run_next = 1'b0;
        frame_err_next = 1'b1;
      end else begin
        rp_next[0] = `MVS_SLAVE_ADDR;
        crc_bus.clear = 1'b1;
        crc_pend_next = 1'b1;
        crc_idx_next = 3'h0;
        if (exc == 8'h00) begin
          rp_next[1] = `MVS_FUNC_READ;
          rp_next[2] = 8'(qty << 1);
          rp_next[3] = visibility_range_meters[15:8];
          rp_next[4] = visibility_range_meters[7:0];
          rp_len_next = 3'h5;
        end else begin
          rp_next[1] = rq_reg[1] | `MVS_EXC_FLAG;
          rp_next[2] = exc;
          rp_len_next = 3'h3;
        end
      end
    end else if (crc_pend_reg && !crc_bus.busy) begin
      if (crc_idx_reg != rp_len_reg) begin
        crc_bus.load = 1'b1;
        crc_bus.data = rp_reg[crc_idx_reg];
        crc_idx_next = crc_idx_reg + 3'h1;
      end else begin
        rp_next[rp_len_reg] = crc_bus.crc[7:0];
        rp_next[rp_len_reg + 3'h1] = crc_bus.crc[15:8];
        rp_len_next = rp_len_reg + 3'h2;
        rp_idx_next = 3'h0;
        crc_pend_next = 1'b0;
        crc_run_next = 1'b0;
        tx_st_next = mvs_pkg::MVS_TX_START;
        tx_en_next = 1'b1;
      end
    end
    // character transmitter, back to back within the reply
    unique case (tx_st_reg)
      mvs_pkg::MVS_TX_IDLE: tx_line_next = 1'b1;
      mvs_pkg::MVS_TX_START: begin
        tx_sh_next = {1'b1, par_even(rp_reg[rp_idx_reg]), rp_reg[rp_idx_reg]};
        tx_line_next = 1'b0;
        tx_cnt_next = 13'(BIT_CYC - 1);
        tx_bit_next = 4'h0;
        tx_st_next = mvs_pkg::MVS_TX_BITS;
      end
      mvs_pkg::MVS_TX_BITS: begin
        if (tx_cnt_reg != 13'h0) begin
          tx_cnt_next = tx_cnt_reg - 13'h1;
        end else if (tx_bit_reg != 4'hA) begin
          tx_cnt_next = 13'(BIT_CYC - 1);
          tx_line_next = tx_sh_reg[0];
          tx_sh_next = {1'b1, tx_sh_reg[9:1]};
          tx_bit_next = tx_bit_reg + 4'h1;
        end else begin
          tx_st_next = mvs_pkg::MVS_TX_STOP;
        end
      end
      mvs_pkg::MVS_TX_STOP: begin
        rp_idx_next = rp_idx_reg + 3'h1;
        if (rp_idx_reg + 3'h1 == rp_len_reg) begin
          tx_st_next = mvs_pkg::MVS_TX_IDLE;
          tx_en_next = 1'b0;
        end else begin
          tx_st_next = mvs_pkg::MVS_TX_START;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crc_run_reg <= 1'b0;
      crc_pend_reg <= 1'b0;
      crc_idx_reg <= 3'h0;
      for (int i = 0; i < 7; i++) rp_reg[i] <= 8'h00;
      rp_len_reg <= 3'h0;
      rp_idx_reg <= 3'h0;
      frame_err_reg <= 1'b0;
      tx_st_reg <= mvs_pkg::MVS_TX_IDLE;
      tx_cnt_reg <= 13'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
      tx_line_reg <= 1'b1;
      tx_en_reg <= 1'b0;
    end else begin
      crc_run_reg <= crc_run_next;
      crc_pend_reg <= crc_pend_next;
      crc_idx_reg <= crc_idx_next;
      rp_reg <= rp_next;
      rp_len_reg <= rp_len_next;
      rp_idx_reg <= rp_idx_next;
      frame_err_reg <= frame_err_next;
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      tx_line_reg <= tx_line_next;
      tx_en_reg <= tx_en_next;
    end
  end

  // line and reply framing checks
  property p_idle_high; @(posedge clk_sys) disable iff (reset) !tx_en_reg |-> tx_line_reg; endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_start_bit; @(posedge clk_sys) disable iff (reset)
    tx_st_reg == mvs_pkg::MVS_TX_START |=> !tx_line_reg && tx_en_reg; endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit missing");
  property p_reply_addr; @(posedge clk_sys) disable iff (reset)
    $rose(tx_en_reg) |-> rp_reg[0] == 8'h01; endproperty
  a_reply_addr: assert property (p_reply_addr) else $error("reply address wrong");
  property p_reply_func; @(posedge clk_sys) disable iff (reset)
    $rose(tx_en_reg) |-> (rp_reg[1] == 8'h03 && rp_len_reg == 3'h7) || (rp_reg[1][7] && rp_len_reg == 3'h5);
  endproperty
  a_reply_func: assert property (p_reply_func) else $error("reply function or length wrong");
  property p_count; @(posedge clk_sys) disable iff (reset)
    ($rose(tx_en_reg) && rp_reg[1] == 8'h03) |-> rp_reg[2] == 8'h02; endproperty
  a_count: assert property (p_count) else $error("byte count wrong");
  property p_bad_crc; @(posedge clk_sys) disable iff (reset)
    (crc_run_reg && !crc_pend_reg && !crc_bus.busy && crc_idx_reg == 3'h6 && crc_bus.crc != rx_crc && !frame_end)
    |=> frame_err_reg && !crc_run_reg; endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("crc mismatch not flagged");
  property p_only_03; @(posedge clk_sys) disable iff (reset)
    ($rose(tx_en_reg) && rq_reg[1] != 8'h03) |-> rp_reg[2] == 8'h01; endproperty
  a_only_03: assert property (p_only_03) else $error("bad function not rejected");
  property p_crc_tail; @(posedge clk_sys) disable iff (reset)
    (crc_pend_reg && !crc_bus.busy && crc_idx_reg == rp_len_reg)
    |=> rp_reg[rp_len_reg - 3'h1] == $past(crc_bus.crc[15:8]); endproperty
  a_crc_tail: assert property (p_crc_tail) else $error("crc high byte not last");
endmodule

// ---- dv/mvs_master_model.sv ----
// modbus rtu master model: sends request frames and collects reply bytes
`timescale 1ns/1ps
`include "mvs_defs.svh"
module mvs_master_model #(
  parameter int BIT_CYC = `MVS_BIT_CYC
) (
  input wire logic clk_sys,
  output logic rx_line,
  input wire logic tx_line_reg,
  input wire logic tx_en_reg
);
  logic [7:0] rx_bytes[$];
  int char_errs;
  logic par_flip;
  // idle line is high between frames
  initial begin
    rx_line = 1'b1;
    char_errs = 0;
    par_flip = 1'b0;
  end
  // one character: start, eight data lsb first, even parity, stop
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] bits;
    bits = {1'b1, ^b ^ par_flip, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      rx_line <= bits[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
  endtask
  // characters leave back to back with no idle between them
  task automatic send_frame(input logic [7:0] f[$]);
    foreach (f[i]) send_byte(f[i]);
  endtask
  // reply receiver: samples each bit at its centre, checks parity and stop
  always begin
    logic [9:0] sh;
    @(negedge tx_line_reg iff tx_en_reg === 1'b1);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      sh[i] = tx_line_reg;
    end
    if (sh[9] !== 1'b1 || ^sh[8:0] !== 1'b0) begin
      char_errs++;
    end
    rx_bytes.push_back(sh[7:0]);
  end
endmodule

// ---- dv/modbus_rtu_visibility_slave_tb.sv ----
// self-checking bench for the modbus rtu visibility slave
`timescale 1ns/1ps
`include "mvs_defs.svh"
module modbus_rtu_visibility_slave_tb;
  localparam int BIT = 40;
  localparam int GAP = BIT * 11 * 4;
  localparam int LIMIT = 90000;
  logic clk_sys;
  logic reset;
  logic rx_line;
  logic tx_line_reg;
  logic tx_en_reg;
  logic frame_err_reg;
  logic [15:0] visibility_range_meters;
  logic [7:0] fc;
  logic bad_par;
  int miscompares;
  int n_tests;
  int cycles;
  mvs_slave #(.GAP_CYC(GAP), .BIT_CYC(BIT)) i_dut (.clk_sys(clk_sys), .reset(reset), .rx_line(rx_line),
    .tx_line_reg(tx_line_reg), .tx_en_reg(tx_en_reg),
    .visibility_range_meters(visibility_range_meters), .frame_err_reg(frame_err_reg));
  mvs_master_model #(.BIT_CYC(BIT)) i_master (.clk_sys(clk_sys), .rx_line(rx_line), .tx_line_reg(tx_line_reg),
    .tx_en_reg(tx_en_reg));
  // reference crc: all ones start, byte into low half, eight reflected shifts
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check1(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one request frame, then the expected reply or silence
  task automatic run_case(input logic [7:0] sa, input logic [7:0] f, input logic [15:0] st,
    input logic [15:0] qt, input logic bad_crc);
    logic [7:0] req[$];
    logic [7:0] exp[$];
    logic [15:0] c;
    int t;
    req = {sa, f, st[15:8], st[7:0], qt[15:8], qt[7:0]};
    c = crc16(req);
    req.push_back(c[7:0] ^ {7'h00, bad_crc});
    req.push_back(c[15:8]);
    exp.delete();
    if (sa == 8'h01 && !bad_crc && !bad_par) begin
      if (f != 8'h03) begin
        exp = {sa, f | 8'h80, 8'h01};
      end else if (qt != 16'h0001) begin
        exp = {sa, f | 8'h80, 8'h03};
      end else if (st != 16'h0000) begin
        exp = {sa, f | 8'h80, 8'h02};
      end else begin
        exp = {sa, f, 8'h02, visibility_range_meters[15:8], visibility_range_meters[7:0]};
      end
      c = crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    i_master.rx_bytes.delete();
    i_master.char_errs = 0;
    i_master.par_flip = bad_par;
    i_master.send_frame(req);
    t = 0;
    while (tx_en_reg !== 1'b1 && t < GAP + 2000) begin
      @(posedge clk_sys);
      t++;
    end
    check1("reply_started", exp.size() != 0, tx_en_reg);
    t = 0;
    while (tx_en_reg === 1'b1 && t < 400000) begin
      @(posedge clk_sys);
      t++;
    end
    repeat (BIT) @(posedge clk_sys);
    check8("reply_len", 8'(exp.size()), 8'(i_master.rx_bytes.size()));
    foreach (exp[i]) check8("reply_byte", exp[i], i_master.rx_bytes[i]);
    check8("char_errs", 8'h00, 8'(i_master.char_errs));
    check1("frame_err", bad_crc | bad_par, frame_err_reg);
  endtask
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // cycle ceiling against hangs
  initial cycles = 0;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    reset = 1'b1;
    visibility_range_meters = 16'h2710;
    fc = 8'h03;
    bad_par = 1'b0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(90086));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check1("tx_idle", 1'b1, tx_line_reg);
    check1("tx_en_idle", 1'b0, tx_en_reg);
    run_case(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0);
    @(posedge clk_sys);
    visibility_range_meters <= 16'($urandom);
    fc <= 8'($urandom_range(4, 127));
    @(posedge clk_sys);
    run_case(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0);
    run_case(8'h01, fc, 16'h0000, 16'h0001, 1'b0);
    run_case(8'h01, 8'h03, 16'h0000, 16'h0002, 1'b0);
    run_case(8'h01, 8'h03, 16'($urandom_range(1, 65535)), 16'h0001, 1'b0);
    run_case(8'h02, 8'h03, 16'h0000, 16'h0001, 1'b0);
    // every character carries a wrong parity bit: silence and an error flag
    bad_par = 1'b1;
    run_case(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0);
    bad_par = 1'b0;
    run_case(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b1);
    run_case(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0);
    wrap_up();
  end
endmodule
